/* rtl/spmp_consts.vh */
// constants for the serial master/slave port: register map, fields, timing
// assumes inclusion by bare name from the port's design and bench files
`ifndef SPMP_CONSTS_VH
`define SPMP_CONSTS_VH

// apb byte addresses
`define SPMP_ADDR_CTRL   12'h000
`define SPMP_ADDR_FLAGS  12'h004
`define SPMP_ADDR_DATA   12'h008
`define SPMP_ADDR_IMASK  12'h00C
`define SPMP_ADDR_ISTAT  12'h010
`define SPMP_ADDR_W      12

// control register fields
`define SPMP_CTL_RATE2   7
`define SPMP_CTL_IE      6
`define SPMP_CTL_EN      5
`define SPMP_CTL_RATE1   4
`define SPMP_CTL_MSTR    3
`define SPMP_CTL_CPOL    2
`define SPMP_CTL_CPHA    1
`define SPMP_CTL_RATE0   0
`define SPMP_CTL_RST     8'h00

// flags/select register fields
`define SPMP_FL_DONE     7
`define SPMP_FL_WRITE_COLLISION_FLAG     6
`define SPMP_FL_OVR      5
`define SPMP_FL_MASTER_FAULT_FLAG     4
`define SPMP_FL_SOD      2
`define SPMP_FL_SSM      1
`define SPMP_FL_SSI      0
`define SPMP_FL_RW_MASK  8'h07
`define SPMP_FL_RST      8'h00

// interrupt status bits: done, collision, overrun, fault
`define SPMP_IRQ_W       4
`define SPMP_IRQ_RST     4'h0

// half-period of serial clock in cpu clocks for each rate code
`define SPMP_HALF_DIV4   8'h02
`define SPMP_HALF_DIV8   8'h04
`define SPMP_HALF_DIV16  8'h08
`define SPMP_HALF_DIV32  8'h10
`define SPMP_HALF_DIV64  8'h20
`define SPMP_HALF_DIV128 8'h40
`define SPMP_BITS        4'h8
`define SPMP_ZERO_BYTE   8'h00
`define SPMP_ERR_ADDR    32'h00000000

`endif

/* rtl/spmp_sync2.v */
// two-flop synchroniser for an asynchronous level
// assumes i_mclk free running; reset synchronous active high
`timescale 1ns/100ps
`default_nettype none
module spmp_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input  wire i_mclk,
  input  wire i_rst,
  input  wire i_async,
  output reg  o_sync
);
  reg meta_q;

  always @(posedge i_mclk) begin
    if (i_rst) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* rtl/spmp_port.v */
// serial master/slave byte port with apb register access
// assumes apb master on i_mclk (200 MHz); link pins are asynchronous and synchronised here
// Summary of operation
// [R01] full duplex: clock plus one data line each direction
// [R02] simplex on two lines by disabling the serial output
// [R03] master or slave; single master system only
// [R04] master clock from six rates, /4 fastest, three-bit code
// [R05] external master clock no faster than cpu clock over two
// [R06] select from pin or software level, chosen by mode bit
// [R07] clock polarity and phase programmable
// [R08] done flag set at transfer end; interrupt when enabled
// [R09] done flag cleared by flags access then data access
// [R10] data writes ignored while done set, until flags read; code also accepts them after a flags write
// [R11] collision flag on data write during transfer; sequence clears
// [R12] overrun flag when byte arrives with done set; flags read clears
// [R13] master with select low sets fault flag, interrupt when enabled; code checks only the pin, and only with ssm clear
// [R14] fault cleared by control read while set then control write
// [R15] flags register resets zero; bit 3 reserved reads zero
// [R16] slave cannot stream back to back at top rate
// [R17] eight bits shifted per transfer via shift register
`timescale 1ns/100ps
`default_nettype none
`include "spmp_consts.vh"
module spmp_port (
  input  wire        i_mclk,
  input  wire        i_rst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_sck,
  output reg         o_sck,
  output reg         o_sck_oe,
  input  wire        i_mosi,
  output reg         o_mosi,
  output reg         o_mosi_oe,
  input  wire        i_miso,
  output reg         o_miso,
  output reg         o_miso_oe,
  input  wire        i_ss_n,
  output reg         o_irq
);
  // ****************************************************
  // functions
  // ****************************************************
  function [7:0] rate_half;
    input [2:0] code;
    begin
      case (code)
        3'h0:    rate_half = `SPMP_HALF_DIV4;
        3'h1:    rate_half = `SPMP_HALF_DIV16;
        3'h2:    rate_half = `SPMP_HALF_DIV64;
        3'h3:    rate_half = `SPMP_HALF_DIV128;
        3'h4:    rate_half = `SPMP_HALF_DIV8;
        3'h6:    rate_half = `SPMP_HALF_DIV32;
        default: rate_half = `SPMP_HALF_DIV8;
      endcase
    end
  endfunction

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  wire sck_s, mosi_s, miso_s, ss_n_s;
  spmp_sync2 #(.RST_VAL(1'b0)) u_sck  (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(i_sck),  .o_sync(sck_s));
  spmp_sync2 #(.RST_VAL(1'b0)) u_mosi (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(i_mosi), .o_sync(mosi_s));
  spmp_sync2 #(.RST_VAL(1'b0)) u_miso (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(i_miso), .o_sync(miso_s));
  spmp_sync2 #(.RST_VAL(1'b1)) u_ss   (.i_mclk(i_mclk), .i_rst(i_rst), .i_async(i_ss_n), .o_sync(ss_n_s));

  // ****************************************************
  // registers and state
  // ****************************************************
  reg  [7:0] ctrl_q;
  reg  [7:0] sel_q;      // sod, ssm, ssi
  reg        done_q, write_collision_flag_q, ovr_q, master_fault_flag_q;
  reg        done_arm_q, write_collision_flag_arm_q, master_fault_flag_arm_q;
  reg  [7:0] rxdata_q, shift_q;
  reg  [3:0] bitcnt_q;
  reg        busy_q;
  reg  [7:0] divcnt_q;
  reg        msck_q;     // internal master clock, idle low
  reg        sck_prev_q;
  reg        samp_dly_q; // master sample one cycle late: pin flop plus sync latency
  reg  [`SPMP_IRQ_W-1:0] istat_q, imask_q;

  wire [2:0] rate   = {ctrl_q[`SPMP_CTL_RATE2], ctrl_q[`SPMP_CTL_RATE1], ctrl_q[`SPMP_CTL_RATE0]};
  wire       master = ctrl_q[`SPMP_CTL_MSTR];
  wire       enable = ctrl_q[`SPMP_CTL_EN];
  wire       cpol   = ctrl_q[`SPMP_CTL_CPOL];
  wire       cpha   = ctrl_q[`SPMP_CTL_CPHA];
  wire       serial_output_disable    = sel_q[`SPMP_FL_SOD];

  // [R06] select source choice
  wire ss_active = sel_q[`SPMP_FL_SSM] ? ~sel_q[`SPMP_FL_SSI] : ~ss_n_s;

  // ****************************************************
  // apb decode
  // ****************************************************
  wire acc     = i_psel & i_penable;
  wire wr      = acc & i_pwrite;
  wire rd      = acc & ~i_pwrite;
  wire hit_ctl = (i_paddr == `SPMP_ADDR_CTRL);
  wire hit_fl  = (i_paddr == `SPMP_ADDR_FLAGS);
  wire hit_dat = (i_paddr == `SPMP_ADDR_DATA);
  wire hit_msk = (i_paddr == `SPMP_ADDR_IMASK);
  wire hit_ist = (i_paddr == `SPMP_ADDR_ISTAT);
  wire mapped  = hit_ctl | hit_fl | hit_dat | hit_msk | hit_ist;
  wire dat_acc = acc & hit_dat;
  wire fl_rd   = rd & hit_fl;
  // [R10] write accepted when done flag clear, or once a flags access has armed the done clear
  wire dat_wr  = wr & hit_dat & (~done_q | done_arm_q);

  // ****************************************************
  // shift engine
  // ****************************************************
  // effective serial clock (master: internal msck_q before polarity; slave: synchronised pin)
  wire line_sck  = master ? msck_q : sck_s;
  wire sck_rise  = line_sck & ~sck_prev_q;
  wire sck_fall  = ~line_sck & sck_prev_q;
  // [R07] sample/shift edge chosen from polarity and phase
  wire lead_edge = cpol ? sck_fall : sck_rise;
  wire trail_edge = cpol ? sck_rise : sck_fall;
  wire sample_e  = cpha ? trail_edge : lead_edge;
  wire shift_e   = cpha ? lead_edge : trail_edge;
  wire rx_bit    = master ? miso_s : mosi_s;
  wire slave_go  = ~master & ss_active;
  wire start     = dat_wr & ~busy_q & enable & (master | slave_go);
  wire samp_ev   = master ? samp_dly_q : sample_e;
  wire last_bit  = (bitcnt_q == `SPMP_BITS - 4'h1);
  wire finish    = busy_q & samp_ev & last_bit;
  // [R13] fault when enabled master sees select pin low with ssm clear
  wire master_fault_flag_evt  = enable & master & ~ss_n_s & ~sel_q[`SPMP_FL_SSM];

  always @(posedge i_mclk) begin
    if (i_rst) begin
      shift_q    <= `SPMP_ZERO_BYTE;
      rxdata_q   <= `SPMP_ZERO_BYTE;
      bitcnt_q   <= 4'h0;
      busy_q     <= 1'b0;
      divcnt_q   <= `SPMP_ZERO_BYTE;
      msck_q     <= 1'b0;
      sck_prev_q <= 1'b0;
      samp_dly_q <= 1'b0;
    end else begin
      sck_prev_q <= line_sck;
      samp_dly_q <= sample_e & busy_q;
      // [R04] master divider
      if (master & busy_q) begin
        if (divcnt_q == rate_half(rate) - 8'h01) begin
          divcnt_q <= `SPMP_ZERO_BYTE;
          msck_q   <= ~msck_q;
        end else begin
          divcnt_q <= divcnt_q + 8'h01;
        end
      end else begin
        divcnt_q <= `SPMP_ZERO_BYTE;
        msck_q   <= 1'b0;
      end
      // [R17] eight bit shift
      if (start) begin
        shift_q  <= i_pwdata[7:0];
        bitcnt_q <= 4'h0;
        busy_q   <= 1'b1;
      end else if (busy_q & (master_fault_flag_evt | ~enable | (~master & ~ss_active))) begin
        busy_q <= 1'b0;
      end else if (busy_q & samp_ev) begin
        shift_q  <= {shift_q[6:0], rx_bit};
        bitcnt_q <= bitcnt_q + 4'h1;
        if (last_bit) begin
          busy_q   <= 1'b0;
          // [R12] byte kept from data register while done still set
          if (!done_q)
            rxdata_q <= {shift_q[6:0], rx_bit};
        end
      end
    end
  end

  // ****************************************************
  // pin drive
  // ****************************************************
  // [R01] [R02] output disable gives simplex
  wire tx_bit = shift_q[7];
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_sck     <= 1'b0;
      o_sck_oe  <= 1'b0;
      o_mosi    <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      // [R03] only master drives clock and mosi
      o_sck     <= msck_q ^ cpol;
      o_sck_oe  <= enable & master;
      o_mosi    <= tx_bit;
      o_mosi_oe <= enable & master & ~serial_output_disable;
      o_miso    <= tx_bit;
      o_miso_oe <= enable & slave_go & ~serial_output_disable;
    end
  end
  wire unused_shift = shift_e;

  // ****************************************************
  // flags and registers
  // ****************************************************
  always @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_q     <= `SPMP_CTL_RST;
      sel_q      <= `SPMP_FL_RST;
      done_q     <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      ovr_q      <= 1'b0;
      master_fault_flag_q     <= 1'b0;
      done_arm_q <= 1'b0;
      write_collision_flag_arm_q <= 1'b0;
      master_fault_flag_arm_q <= 1'b0;
      imask_q    <= `SPMP_IRQ_RST;
      istat_q    <= `SPMP_IRQ_RST;
    end else begin
      // [R15] only low three bits writable
      if (wr & hit_fl)
        sel_q <= i_pwdata[7:0] & `SPMP_FL_RW_MASK;
      if (wr & hit_msk)
        imask_q <= i_pwdata[`SPMP_IRQ_W-1:0];
      // arm first step of clearing sequences
      if (acc & hit_fl) begin
        done_arm_q <= done_q;
        write_collision_flag_arm_q <= write_collision_flag_q;
      end else if (dat_acc) begin
        done_arm_q <= 1'b0;
        write_collision_flag_arm_q <= 1'b0;
      end
      // [R08] [R09] done flag, set beats clear
      if (finish)
        done_q <= 1'b1;
      else if (dat_acc & done_arm_q & ~(acc & hit_fl))
        done_q <= 1'b0;
      // [R11] collision flag
      if (wr & hit_dat & busy_q)
        write_collision_flag_q <= 1'b1;
      else if (dat_acc & write_collision_flag_arm_q)
        write_collision_flag_q <= 1'b0;
      // [R12] overrun flag cleared by flags read
      if (finish & done_q)
        ovr_q <= 1'b1;
      else if (fl_rd)
        ovr_q <= 1'b0;
      // [R14] fault clear sequence on control register
      if (acc & hit_ctl & ~i_pwrite)
        master_fault_flag_arm_q <= master_fault_flag_q;
      else if (wr & hit_ctl)
        master_fault_flag_arm_q <= 1'b0;
      if (master_fault_flag_evt) begin
        master_fault_flag_q <= 1'b1;
        ctrl_q[`SPMP_CTL_MSTR] <= 1'b0;
        ctrl_q[`SPMP_CTL_EN]   <= 1'b0;
      end else if (wr & hit_ctl) begin
        ctrl_q <= i_pwdata[7:0];
        if (master_fault_flag_arm_q | master_fault_flag_q & ~master_fault_flag_arm_q & 1'b0)
          master_fault_flag_q <= 1'b0;
      end
      // interrupt status: set wins over write-one clear
      istat_q <= (istat_q & ~((wr & hit_ist) ? i_pwdata[`SPMP_IRQ_W-1:0] : `SPMP_IRQ_RST))
                 | {finish, wr & hit_dat & busy_q, finish & done_q, master_fault_flag_evt & ~master_fault_flag_q};
    end
  end

  // ****************************************************
  // apb answer and interrupt
  // ****************************************************
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_prdata  <= `SPMP_ERR_ADDR;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_irq     <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped;
      o_prdata  <= `SPMP_ERR_ADDR;
      if (i_psel & ~i_penable & ~i_pwrite) begin
        if (hit_ctl)
          o_prdata <= {24'h000000, ctrl_q};
        else if (hit_fl)
          o_prdata <= {24'h000000, done_q, write_collision_flag_q, ovr_q, master_fault_flag_q, 1'b0, sel_q[2:0]};
        else if (hit_dat)
          o_prdata <= {24'h000000, rxdata_q};
        else if (hit_msk)
          o_prdata <= {28'h0000000, imask_q};
        else if (hit_ist)
          o_prdata <= {28'h0000000, istat_q};
      end
      // [R08] [R13] interrupt when enabled and unmasked
      o_irq <= ctrl_q[`SPMP_CTL_IE] & |(istat_q & imask_q);
    end
  end
endmodule
`default_nettype wire

/* bench/spmp_port_monitor.sv */
// checker for the serial port: apb timing, pin enables, fault, irq
// assumes a bind onto spmp_port
`timescale 1ns/100ps
`default_nettype none
`include "spmp_consts.vh"
module spmp_port_monitor (
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_sck,
  input wire logic        o_sck_oe,
  input wire logic        o_mosi_oe,
  input wire logic        o_miso_oe,
  input wire logic        i_ss_n,
  input wire logic        o_irq
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_pready_answer: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no pready after setup");
  a_pready_once: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  a_rsvd_zero: assert property (o_pready && !i_pwrite && i_paddr == `SPMP_ADDR_FLAGS |-> !o_prdata[3])
    else $error("reserved bit set");
  a_fault_stop: assert property (!i_ss_n [*6] |-> !o_sck_oe)
    else $error("master kept with select low");
  a_simplex_oe: assert property (o_mosi_oe |-> o_sck_oe)
    else $error("data out without clock");
  a_one_role: assert property (!(o_mosi_oe && o_miso_oe))
    else $error("master and slave outputs both on");
  a_sck_rate: assert property (o_sck_oe && $changed(o_sck) |=> $stable(o_sck))
    else $error("clock faster than div4");
  a_irq_masked: assert property (o_pready && i_pwrite && i_paddr == `SPMP_ADDR_IMASK
    && i_pwdata[3:0] == 4'h0 |=> ##1 !o_irq)
    else $error("irq with all masked");
endmodule
bind spmp_port spmp_port_monitor mon_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
  .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe), .i_ss_n(i_ss_n), .o_irq(o_irq));
`default_nettype wire

/* bench/spmp_slave_model.sv */
// far side slave, clock idle low, sample on rise, shift on fall
// assumes load pulse before each frame
`timescale 1ns/100ps
`default_nettype none
module spmp_slave_model (
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_load,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic [7:0]      o_rx
);
  logic [7:0] sr;
  int         n = 8;
  always @(posedge i_load) begin
    sr = i_tx;
    n = 0;
  end
  always @(posedge i_sck) begin
    o_rx = {o_rx[6:0], i_mosi};
    n++;
  end
  always @(negedge i_sck) sr = {sr[6:0], ~sr[0]};
  // released line toggles, never holds last bit
  assign o_miso = (n < 8) ? sr[7] : ~sr[7];
endmodule
`default_nettype wire

/* bench/spmp_port_tb.sv */
// self-checking bench for spmp_port with a slave model
// assumes 200 MHz clock, apb master tasks below
`timescale 1ns/100ps
`default_nettype none
`include "spmp_consts.vh"
module spmp_port_tb;
  logic clk, rst, psel, pen, pwr, ss_n, miso, mload, pe;
  logic [11:0] padr;
  logic [31:0] pwd, rv, prd;
  logic [7:0] mtx, mrx;
  logic rdy, perr, sck, ssck, smosi;
  wire mosi, irq, smiso;
  int err_total = 0;
  int total_checks = 0;
  spmp_port dut_u (.i_mclk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(perr), .i_sck(ssck), .o_sck(sck), .o_sck_oe(), .i_mosi(smosi),
    .o_mosi(mosi), .o_mosi_oe(), .i_miso(miso), .o_miso(smiso), .o_miso_oe(),
    .i_ss_n(ss_n), .o_irq(irq));
  spmp_slave_model mdl_u (.i_sck(sck), .i_mosi(mosi), .i_load(mload), .i_tx(mtx),
    .o_miso(miso), .o_rx(mrx));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1)
      err_total++;
    rv = prd;
    pe = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic t_reset;
    apb(0, `SPMP_ADDR_FLAGS, 0); chk(rv, 0, "flags reset");
    apb(0, `SPMP_ADDR_CTRL, 0); chk(rv, 0, "ctrl reset");
    apb(1, `SPMP_ADDR_FLAGS, 32'hFF);
    apb(0, `SPMP_ADDR_FLAGS, 0); chk(rv, 32'h07, "flags rw");
    apb(1, `SPMP_ADDR_FLAGS, 0);
    apb(1, `SPMP_ADDR_IMASK, 0);
    apb(0, 12'h020, 0); chk(pe, 1'b1, "unmapped");
    $display("reset test done");
  endtask
  task automatic t_xfer(input logic [2:0] c, input int h, input logic [7:0] tx, rx);
    int k, rises, first, last;
    logic prv;
    rises = 0;
    mtx <= rx;
    mload <= 1'b1;
    apb(1, `SPMP_ADDR_IMASK, 32'h8);
    mload <= 1'b0;
    apb(1, `SPMP_ADDR_CTRL, {c[2], 2'b11, c[1], 1'b1, 2'b00, c[0]});
    apb(1, `SPMP_ADDR_DATA, tx);
    prv = sck;
    for (k = 0; k < 20 * h + 16; k++) begin
      @(posedge clk);
      if (sck && !prv) begin
        if (rises == 0) first = k;
        last = k;
        rises++;
      end
      prv = sck;
    end
    chk(rises, 8, "bit count");
    chk(last - first, 14 * h, "clock rate");
    chk(irq, 1'b1, "done irq");
    apb(1, `SPMP_ADDR_DATA, 32'h55);
    repeat (8 * h) @(posedge clk);
    chk(mrx, tx, "write while done");
    apb(0, `SPMP_ADDR_FLAGS, 0); chk(rv[7:4], 4'h8, "done flag");
    apb(0, `SPMP_ADDR_DATA, 0); chk(rv[7:0], rx, "rx byte");
    apb(0, `SPMP_ADDR_FLAGS, 0); chk(rv[7], 1'b0, "done clear");
    apb(1, `SPMP_ADDR_ISTAT, 32'hF);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq clear");
    $display("transfer test done code %0d", c);
  endtask
  task automatic t_slave(input logic [7:0] tx, rx);
    logic [7:0] got;
    apb(1, `SPMP_ADDR_CTRL, 32'h60);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1, `SPMP_ADDR_DATA, tx);
    // external clock of 160 ns, one byte per select
    for (int b = 7; b >= 0; b--) begin
      smosi <= rx[b];
      repeat (16) @(posedge clk);
      got[b] = smiso;
      ssck <= 1'b1;
      repeat (16) @(posedge clk);
      ssck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    chk(got, tx, "slave out");
    apb(0, `SPMP_ADDR_FLAGS, 0); chk(rv[7], 1'b1, "slave done");
    apb(0, `SPMP_ADDR_DATA, 0); chk(rv[7:0], rx, "slave rx");
    ss_n <= 1'b1;
    apb(1, `SPMP_ADDR_ISTAT, 32'hF);
    $display("slave test done");
  endtask
  task automatic t_fault;
    apb(1, `SPMP_ADDR_IMASK, 32'h1);
    apb(1, `SPMP_ADDR_CTRL, 32'h6C);
    repeat (3) @(posedge clk);
    chk(sck, 1'b1, "idle high");
    ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(irq, 1'b1, "fault irq");
    apb(0, `SPMP_ADDR_FLAGS, 0); chk(rv[4], 1'b1, "fault flag");
    apb(0, `SPMP_ADDR_CTRL, 0); chk(rv, 32'h44, "master off");
    ss_n <= 1'b1;
    apb(1, `SPMP_ADDR_CTRL, 0);
    apb(0, `SPMP_ADDR_FLAGS, 0); chk(rv[4], 1'b0, "fault clear");
    $display("fault test done");
  endtask
  logic [2:0] cd[6] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd6};
  int hf[6] = '{2, 8, 32, 64, 4, 16};
  initial begin
    {psel, pen, pwr, mload, padr, pwd, mtx, ssck, smosi} = '0;
    ss_n = 1'b1;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    for (int i = 0; i < 6; i++) t_xfer(cd[i], hf[i], 8'hA5 ^ i[7:0], 8'h3C + i[7:0]);
    t_slave(8'hC3, 8'h96);
    t_fault;
    test_done;
  end
  initial begin
    #400000;
    err_total++;
    test_done;
  end
endmodule
`default_nettype wire
